// [common/modstream_pkg.sv]
package modstream_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] SAMPLE_OFS = 8'h10;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int GAIN_LSB = 0;
    localparam int SWAP_BIT = 3;
    localparam int FPATH_LSB = 4;
    localparam int SYNC_BIT = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0028;
    localparam logic [1:0] FPATH_BYPASS = 2'h0;

    // ------------------------------------------------------------
    // Interrupt bits
    // ------------------------------------------------------------
    localparam int IRQ_OVR_RISE = 0;
    localparam int IRQ_OVR_FALL = 1;
    localparam int IRQ_SAMPLE = 2;
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MCLK_HZ = 100_000_000;
    localparam int MOD_DIV = 4;
    localparam int FLAG_DIV = 2;
    localparam int INPUT_SWAP_ENABLE_DIV = 512;
    localparam int INPUT_SWAP_ENABLE_HALF = INPUT_SWAP_ENABLE_DIV / 2;
    localparam int SAT_EXIT_MOD_CLKS = 12;
    localparam int LIN_READINGS = 31;
    localparam int SETTLE_READINGS = 62;

    // ------------------------------------------------------------
    // Sample width: extremes +25 and -24 fit in 6 signed bits
    // ------------------------------------------------------------
    localparam int SAMPLE_W = 6;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01
    } bus_state_type;

endpackage : modstream_pkg

// [design/tap_shift.sv]
`timescale 1ns/1ps
module tap_shift #(
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clear,
    input wire logic advance,
    input wire logic bit_in,
    output logic [DEPTH:0] taps
);
    logic [DEPTH-1:0] hist_r;
    logic [DEPTH-1:0] hist_nxt;

    always_comb begin
        hist_nxt = hist_r;
        if (clear) begin
            hist_nxt = '0;
        end else if (advance) begin
            hist_nxt = {hist_r[DEPTH-2:0], bit_in};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hist_r <= '0;
        end else begin
            hist_r <= hist_nxt;
        end
    end

    assign taps = {hist_r, bit_in};
endmodule : tap_shift

// [design/modulator_stream_overrange_logic.sv]
// How it works
// - Gain code 000..110 decodes to gain 1..64, doubling each step.
// - Amplifier input_swap_enable clock stops while the swap enable bit is zero.
// - Modulator input input_swap_enable toggles at master clock divided by 512.
// - Sample = 3a2 - 6a3 + 4a4 + 9(b0 - 2b1 + b2).
// - Tap index 0 is newest bit; taps shift once per modulator clock.
// - Raw modulator output selected disables the decimation filter.
// - Stage one density comes from the analog modulator; passed through.
// - No self-reset: streams pass unchanged under overdrive.
// - Filter recovery in readings is the filter's own behaviour.
// - Saturation exit within 12 modulator clocks belongs to the analog side.
// - Over-range flag high while comparator says input exceeds full scale.
// - Comparator sampled at half the modulator rate drives the flag.
// - Flag pulses last at least one half-modulator-rate period.
// - Modulator clock enable is master clock divided by four.
// - Bypass mode drives raw streams and bit clock on output pins.
// - Filter path code 00 selects bypass and modulator output mode.
`timescale 1ns/1ps
module modulator_stream_overrange_logic (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hsel,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic stage_one_stream,
    input wire logic stage_two_stream,
    input wire logic overrange_cmp,
    input wire logic sync_in,
    output logic [6:0] amp_gain,
    output logic amp_input_swap_enable_clk,
    output logic mod_input_swap_enable_clk,
    output logic filter_enable,
    output logic [5:0] sample_word,
    output logic sample_valid,
    output logic raw_stage_one,
    output logic raw_stage_two,
    output logic raw_bit_clk,
    output logic overrange_flag,
    output logic irq
);
    // ------------------------------------------------------------
    // Clock enables
    // ------------------------------------------------------------
    logic [1:0] mod_cnt_r;
    logic [1:0] mod_cnt_nxt;
    logic half_r;
    logic half_nxt;
    logic [7:0] input_swap_enable_cnt_r;
    logic [7:0] input_swap_enable_cnt_nxt;
    logic mod_input_swap_enable_r;
    logic mod_input_swap_enable_nxt;
    logic amp_input_swap_enable_r;
    logic amp_input_swap_enable_nxt;
    logic mod_en;
    logic flag_en;
    logic input_swap_enable_wrap;
    logic sync_now;

    assign mod_en = (mod_cnt_r == 2'(modstream_pkg::MOD_DIV - 1));
    assign flag_en = mod_en && half_r;
    assign input_swap_enable_wrap = (input_swap_enable_cnt_r == 8'(modstream_pkg::INPUT_SWAP_ENABLE_HALF - 1));

    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;

    assign sync_now = sync_in || ctrl_r[modstream_pkg::SYNC_BIT];

    always_comb begin
        mod_cnt_nxt = mod_cnt_r + 2'h1;
        half_nxt = mod_en ? ~half_r : half_r;
        input_swap_enable_cnt_nxt = input_swap_enable_wrap ? 8'h00 : input_swap_enable_cnt_r + 8'h01;
        mod_input_swap_enable_nxt = input_swap_enable_wrap ? ~mod_input_swap_enable_r : mod_input_swap_enable_r;
        amp_input_swap_enable_nxt = amp_input_swap_enable_r;
        if (!ctrl_r[modstream_pkg::SWAP_BIT]) begin
            amp_input_swap_enable_nxt = 1'b0;
        end else if (input_swap_enable_wrap) begin
            amp_input_swap_enable_nxt = ~amp_input_swap_enable_r;
        end
        if (sync_now) begin
            mod_cnt_nxt = 2'h0;
            half_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mod_cnt_r <= 2'h0;
            half_r <= 1'b0;
            input_swap_enable_cnt_r <= 8'h00;
            mod_input_swap_enable_r <= 1'b0;
            amp_input_swap_enable_r <= 1'b0;
        end else begin
            mod_cnt_r <= mod_cnt_nxt;
            half_r <= half_nxt;
            input_swap_enable_cnt_r <= input_swap_enable_cnt_nxt;
            mod_input_swap_enable_r <= mod_input_swap_enable_nxt;
            amp_input_swap_enable_r <= amp_input_swap_enable_nxt;
        end
    end

    // ------------------------------------------------------------
    // Stream combiner
    // ------------------------------------------------------------
    logic [4:0] one_taps;
    logic [4:0] two_taps;

    tap_shift #(.DEPTH(4)) one_shift (
        .mclk(mclk),
        .rst(rst),
        .clear(sync_now),
        .advance(mod_en),
        .bit_in(stage_one_stream),
        .taps(one_taps)
    );

    tap_shift #(.DEPTH(4)) two_shift (
        .mclk(mclk),
        .rst(rst),
        .clear(sync_now),
        .advance(mod_en),
        .bit_in(stage_two_stream),
        .taps(two_taps)
    );

    logic signed [5:0] comb_val;
    always_comb begin
        comb_val = 6'sd0;
        comb_val = comb_val + (one_taps[2] ? 6'sd3 : 6'sd0);
        comb_val = comb_val - (one_taps[3] ? 6'sd6 : 6'sd0);
        comb_val = comb_val + (one_taps[4] ? 6'sd4 : 6'sd0);
        comb_val = comb_val + (two_taps[0] ? 6'sd9 : 6'sd0);
        comb_val = comb_val - (two_taps[1] ? 6'sd18 : 6'sd0);
        comb_val = comb_val + (two_taps[2] ? 6'sd9 : 6'sd0);
    end

    logic [5:0] sample_r;
    logic [5:0] sample_nxt;
    logic valid_r;
    logic valid_nxt;
    logic raw1_r;
    logic raw1_nxt;
    logic raw2_r;
    logic raw2_nxt;
    logic rawclk_r;
    logic rawclk_nxt;
    logic fen_r;
    logic fen_nxt;
    logic [6:0] gain_r;
    logic [6:0] gain_nxt;
    logic bypass;

    assign bypass = (ctrl_r[modstream_pkg::FPATH_LSB +: 2] == modstream_pkg::FPATH_BYPASS);

    always_comb begin
        sample_nxt = sample_r;
        valid_nxt = 1'b0;
        if (mod_en && !sync_now) begin
            sample_nxt = comb_val;
            valid_nxt = 1'b1;
        end
        fen_nxt = ~bypass;
        raw1_nxt = bypass ? stage_one_stream : 1'b0;
        raw2_nxt = bypass ? stage_two_stream : 1'b0;
        rawclk_nxt = bypass ? (mod_cnt_r < 2'h2) : 1'b0;
        case (ctrl_r[modstream_pkg::GAIN_LSB +: 3])
            3'h0: gain_nxt = 7'h01;
            3'h1: gain_nxt = 7'h02;
            3'h2: gain_nxt = 7'h04;
            3'h3: gain_nxt = 7'h08;
            3'h4: gain_nxt = 7'h10;
            3'h5: gain_nxt = 7'h20;
            3'h6: gain_nxt = 7'h40;
            default: gain_nxt = gain_r;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sample_r <= 6'h00;
            valid_r <= 1'b0;
            raw1_r <= 1'b0;
            raw2_r <= 1'b0;
            rawclk_r <= 1'b0;
            fen_r <= 1'b1;
            gain_r <= 7'h01;
        end else begin
            sample_r <= sample_nxt;
            valid_r <= valid_nxt;
            raw1_r <= raw1_nxt;
            raw2_r <= raw2_nxt;
            rawclk_r <= rawclk_nxt;
            fen_r <= fen_nxt;
            gain_r <= gain_nxt;
        end
    end

    // ------------------------------------------------------------
    // Over-range flag
    // ------------------------------------------------------------
    logic flag_r;
    logic flag_nxt;
    always_comb begin
        flag_nxt = flag_en ? overrange_cmp : flag_r;
    end

    // ------------------------------------------------------------
    // AHB-Lite slave and interrupts
    // ------------------------------------------------------------
    modstream_pkg::bus_state_type st_r;
    modstream_pkg::bus_state_type st_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic wr_r;
    logic wr_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [2:0] ist_r;
    logic [2:0] ist_nxt;
    logic [2:0] imask_r;
    logic [2:0] imask_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [2:0] ev;
    logic take;

    assign take = hsel && hready && htrans[1];
    assign ev = {valid_nxt, flag_r && !flag_nxt, !flag_r && flag_nxt};

    always_comb begin
        st_nxt = take ? modstream_pkg::ST_ADDR : modstream_pkg::ST_IDLE;
        addr_nxt = take ? haddr[7:0] : addr_r;
        wr_nxt = take && hwrite;
        ctrl_nxt = ctrl_r;
        ctrl_nxt[modstream_pkg::SYNC_BIT] = 1'b0;
        ist_nxt = ist_r;
        imask_nxt = imask_r;
        rdata_nxt = 32'h0000_0000;
        if (st_r == modstream_pkg::ST_ADDR && wr_r) begin
            unique case (addr_r)
                modstream_pkg::CTRL_OFS: ctrl_nxt = {23'h000000, hwdata[8:0]};
                modstream_pkg::IRQ_STAT_OFS: ist_nxt = ist_r & ~hwdata[2:0];
                modstream_pkg::IRQ_MASK_OFS: imask_nxt = hwdata[2:0];
                default: ;
            endcase
        end
        ist_nxt = ist_nxt | ev;
        if (take && !hwrite) begin
            unique case (haddr[7:0])
                modstream_pkg::CTRL_OFS: rdata_nxt = ctrl_r;
                modstream_pkg::STATUS_OFS: rdata_nxt = {29'h0, fen_r, amp_input_swap_enable_r, flag_r};
                modstream_pkg::IRQ_STAT_OFS: rdata_nxt = {29'h0, ist_r};
                modstream_pkg::IRQ_MASK_OFS: rdata_nxt = {29'h0, imask_r};
                modstream_pkg::SAMPLE_OFS: rdata_nxt = {{26{sample_r[5]}}, sample_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= modstream_pkg::ST_IDLE;
            addr_r <= 8'h00;
            wr_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            ctrl_r <= modstream_pkg::CTRL_RESET;
            ist_r <= 3'h0;
            imask_r <= 3'h0;
            irq_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            addr_r <= addr_nxt;
            wr_r <= wr_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            irq_r <= irq_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign amp_gain = gain_r;
    assign amp_input_swap_enable_clk = amp_input_swap_enable_r;
    assign mod_input_swap_enable_clk = mod_input_swap_enable_r;
    assign filter_enable = fen_r;
    assign sample_word = sample_r;
    assign sample_valid = valid_r;
    assign raw_stage_one = raw1_r;
    assign raw_stage_two = raw2_r;
    assign raw_bit_clk = rawclk_r;
    assign overrange_flag = flag_r;
    assign irq = irq_r;
endmodule : modulator_stream_overrange_logic

// [dv/modstream_properties.sv]
`timescale 1ns/1ps
module modstream_properties (
    input wire logic mclk,
    input wire logic rst,
    input wire logic stage_one_stream,
    input wire logic stage_two_stream,
    input wire logic overrange_cmp,
    input wire logic sync_in,
    input wire logic [6:0] amp_gain,
    input wire logic mod_input_swap_enable_clk,
    input wire logic filter_enable,
    input wire logic [5:0] sample_word,
    input wire logic sample_valid,
    input wire logic raw_stage_one,
    input wire logic raw_bit_clk,
    input wire logic overrange_flag
);
    // ------------
    // Tap history
    // ------------
    logic [3:0] a_r, a_nxt;
    logic [1:0] b_r, b_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic prev_r, seen_r, seen_nxt, chg;
    int exp_y;

    always_comb begin
        chg = mod_input_swap_enable_clk != prev_r;
        cnt_nxt = chg ? 9'h001 : cnt_r + {8'h00, cnt_r != 9'h1FF};
        seen_nxt = !sync_in && (seen_r || chg);
        a_nxt = sample_valid ? {a_r[2:0], stage_one_stream} : a_r;
        b_nxt = sample_valid ? {b_r[0], stage_two_stream} : b_r;
        if (sync_in) begin
            a_nxt = 4'h0;
            b_nxt = 2'h0;
        end
        exp_y = 3 * a_r[1] - 6 * a_r[2] + 4 * a_r[3];
        exp_y = exp_y + 9 * stage_two_stream - 18 * b_r[0] + 9 * b_r[1];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            a_r <= 4'h0;
            b_r <= 2'h0;
            cnt_r <= 9'h000;
            prev_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            a_r <= a_nxt;
            b_r <= b_nxt;
            cnt_r <= cnt_nxt;
            prev_r <= mod_input_swap_enable_clk;
            seen_r <= seen_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    input_swap_enable_period_a: assert property (seen_r && chg |-> cnt_r == 9'h100)
        else $error("input_swap_enable half period wrong");
    sample_gap_a: assert property (
        disable iff (rst || sync_in) sample_valid |=> !sample_valid [*3] ##1 sample_valid)
        else $error("sample spacing wrong");
    sample_sum_a: assert property (
        sample_valid |-> sample_word == 6'(exp_y))
        else $error("combined sample wrong");
    gain_onehot_a: assert property ($onehot(amp_gain))
        else $error("gain not one-hot");
    raw_idle_a: assert property (
        filter_enable [*3] |-> !raw_bit_clk && !raw_stage_one)
        else $error("raw outputs active with filter on");
    flag_high_a: assert property (
        disable iff (rst || sync_in) $rose(overrange_flag) |=> overrange_flag [*7])
        else $error("flag pulse too short");
    flag_low_a: assert property (
        disable iff (rst || sync_in) $fell(overrange_flag) |=> !overrange_flag [*7])
        else $error("flag gap too short");
    flag_source_a: assert property (
        $changed(overrange_flag) |-> overrange_flag == $past(overrange_cmp))
        else $error("flag not from comparator");
    flag_track_a: assert property (disable iff (rst || sync_in)
        $stable(overrange_cmp) [*8] ##1 $stable(overrange_cmp) [*3] |-> overrange_flag == overrange_cmp)
        else $error("flag not tracking comparator");

    cover property (sample_valid && sample_word[5]);
    cover property ($rose(overrange_flag));
    cover property (!filter_enable && raw_bit_clk);
endmodule : modstream_properties

bind modulator_stream_overrange_logic modstream_properties props (
    .mclk(mclk), .rst(rst), .stage_one_stream(stage_one_stream),
    .stage_two_stream(stage_two_stream), .overrange_cmp(overrange_cmp), .sync_in(sync_in),
    .amp_gain(amp_gain), .mod_input_swap_enable_clk(mod_input_swap_enable_clk), .filter_enable(filter_enable),
    .sample_word(sample_word), .sample_valid(sample_valid), .raw_stage_one(raw_stage_one),
    .raw_bit_clk(raw_bit_clk), .overrange_flag(overrange_flag)
);

// [dv/front_end_model.sv]
`timescale 1ns/1ps
module front_end_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sample_valid,
    input wire logic [15:0] pattern,
    output logic stage_one_stream,
    output logic stage_two_stream
);
    logic [3:0] pos_r, pos_nxt;
    logic [15:0] pat_r, pat_nxt;

    // Bits step only after a taken sample, far from the next modulator edge
    always_comb begin
        pos_nxt = sample_valid ? pos_r + 4'h1 : pos_r;
        pat_nxt = sample_valid ? pattern : pat_r;
    end

    always_ff @(posedge mclk) begin
        pos_r <= rst ? 4'h0 : pos_nxt;
        pat_r <= rst ? pattern : pat_nxt;
    end

    assign stage_one_stream = pat_r[pos_r];
    assign stage_two_stream = pat_r[~pos_r];
endmodule : front_end_model

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic mclk, rst, hwrite, hsel, hreadyout, hresp, overrange_cmp, sync_in, v, k0;
    logic stage_one_stream, stage_two_stream, amp_input_swap_enable_clk, mod_input_swap_enable_clk, filter_enable;
    logic sample_valid, raw_stage_one, raw_stage_two, raw_bit_clk, overrange_flag, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [6:0] amp_gain;
    logic [5:0] sample_word;
    logic [15:0] pattern;
    int bad_count, n_tests, p, i, k;

    modulator_stream_overrange_logic dut (.mclk(mclk), .rst(rst), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .stage_one_stream(stage_one_stream), .stage_two_stream(stage_two_stream),
        .overrange_cmp(overrange_cmp), .sync_in(sync_in), .amp_gain(amp_gain),
        .amp_input_swap_enable_clk(amp_input_swap_enable_clk), .mod_input_swap_enable_clk(mod_input_swap_enable_clk), .filter_enable(filter_enable),
        .sample_word(sample_word), .sample_valid(sample_valid), .raw_stage_one(raw_stage_one),
        .raw_stage_two(raw_stage_two), .raw_bit_clk(raw_bit_clk),
        .overrange_flag(overrange_flag), .irq(irq));

    front_end_model fe (.mclk(mclk), .rst(rst), .sample_valid(sample_valid),
        .pattern(pattern), .stage_one_stream(stage_one_stream),
        .stage_two_stream(stage_two_stream));

    task automatic test_done;
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            check("hready", 0, 1);
            test_done();
        end
    endtask : wait_ready

    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    // Edges between two changes of a input_swap_enable clock
    task automatic period(input logic sel);
        p = 0;
        v = sel ? amp_input_swap_enable_clk : mod_input_swap_enable_clk;
        for (k = 0; k < 600 && (sel ? amp_input_swap_enable_clk : mod_input_swap_enable_clk) === v; k++) @(posedge mclk);
        v = sel ? amp_input_swap_enable_clk : mod_input_swap_enable_clk;
        for (k = 0; k < 600 && (sel ? amp_input_swap_enable_clk : mod_input_swap_enable_clk) === v; k++) begin
            @(posedge mclk);
            p++;
        end
    endtask : period

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        overrange_cmp = 1'b0;
        sync_in = 1'b0;
        pattern = 16'hA5C3;
        bad_count = 0;
        n_tests = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check("gain_rst", amp_gain, 7'h01);
        check("filter_rst", filter_enable, 1);
        check("okay", hresp, 0);
        bus(modstream_pkg::CTRL_OFS, 0, 0);
        check("ctrl_rst", rd, modstream_pkg::CTRL_RESET);
        bus(8'h20, 1, 32'hFFFF_FFFF);
        bus(8'h20, 0, 0);
        check("unmapped", rd, 0);
        for (i = 0; i < 8; i++) begin
            bus(modstream_pkg::CTRL_OFS, 1, 32'h28 | 32'(i));
            repeat (3) @(posedge mclk);
            check("gain", amp_gain, 7'h01 << (i == 7 ? 6 : i));
        end
        period(0);
        check("mod_input_swap_enable", p, 256);
        period(1);
        check("amp_input_swap_enable", p, 256);
        bus(modstream_pkg::CTRL_OFS, 1, 32'h20);
        p = 0;
        repeat (3) @(posedge mclk);
        for (k = 0; k < 600; k++) begin
            @(posedge mclk);
            p += amp_input_swap_enable_clk;
        end
        check("input_swap_enable_off", p, 0);
        pattern <= 16'hFFFF;
        bus(modstream_pkg::CTRL_OFS, 1, 32'h08);
        repeat (4) @(posedge mclk);
        check("bypass_filter", filter_enable, 0);
        p = 0;
        i = 0;
        for (k = 0; k < 40; k++) begin
            v = raw_bit_clk;
            @(posedge mclk);
            p += raw_bit_clk & !v;
            i += {raw_stage_two, raw_stage_one};
        end
        check("bit_clk", p, 10);
        check("raw_bits", i, 120);
        bus(modstream_pkg::SAMPLE_OFS, 0, 0);
        check("sample_ones", rd, 32'h0000_0001);
        bus(modstream_pkg::CTRL_OFS, 1, 32'h28);
        sync_in <= 1'b1;
        @(posedge mclk);
        sync_in <= 1'b0;
        repeat (60) @(posedge mclk);
        overrange_cmp <= 1'b1;
        repeat (12) @(posedge mclk);
        check("flag_set", overrange_flag, 1);
        bus(modstream_pkg::STATUS_OFS, 0, 0);
        check("status_flag", rd[0], 1);
        bus(modstream_pkg::IRQ_MASK_OFS, 1, 0);
        repeat (2) @(posedge mclk);
        k0 = irq;
        bus(modstream_pkg::IRQ_MASK_OFS, 1, 32'h7);
        repeat (2) @(posedge mclk);
        check("irq_masked", k0, 0);
        check("irq_mask", irq, 1);
        overrange_cmp <= 1'b0;
        repeat (12) @(posedge mclk);
        check("flag_clr", overrange_flag, 0);
        bus(modstream_pkg::IRQ_STAT_OFS, 0, 0);
        check("irq_edges", rd[2:0], 3'h7);
        bus(modstream_pkg::IRQ_STAT_OFS, 1, 32'h3);
        bus(modstream_pkg::IRQ_STAT_OFS, 0, 0);
        check("irq_w1c", rd[1:0], 2'h0);
        for (i = 0; i < 8; i++) begin
            overrange_cmp <= 1'b1;
            @(posedge mclk);
            overrange_cmp <= 1'b0;
            repeat (9 + i) @(posedge mclk);
        end
        pattern <= 16'h3C5A;
        repeat (200) @(posedge mclk);
        test_done();
    end
endmodule : testbench
